/* File: dnac_ctrl.sv */
// dnac_ctrl: apb slave and control logic for reads and self-timed writes
// of the data nonvolatile array, with unlock sequence and write guards.
// assumes: apb master per amba, single pclk domain, flash and config
// space handled outside through the flash request port.
// Functional notes
// - space select picks data array or flash
// - config select overrides space select
// - write permit clear after power-up
// - hardware never clears write permit
// - abort flag marks interrupted or improper write
// - write trigger settable only, hardware clears
// - completion sets done flag, software clears
// - read trigger blocked in flash/config, self-clears
// - read data ready next cycle
// - value register holds until read or write
// - 55h then aah unlock before each write
// - trigger needs permit from earlier access
// - control, index and value locked while write runs
// - unlock port stores nothing, reads zero
// - writes blocked during power-up timer
// - external programmer refused when protected
// - processor access ignores code protect
// - byte write erases then programs, self-timed
// - value carries byte, index selects location
`timescale 1ns/10ps
module dnac_ctrl #(
    parameter int WRITE_CYC = dnac_pkg::DNAC_WRITE_CYC,
    parameter int PWRT_CYC  = dnac_pkg::DNAC_PWRT_CYC
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     por_n,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [20:0]              table_ptr,
    input  wire logic                     code_protect,
    input  wire logic                     ext_prog_en,
    input  wire logic                     ext_rd,
    input  wire logic                     ext_wr,
    input  wire logic [7:0]               ext_index,
    input  wire logic [7:0]               ext_wdata,
    output logic [7:0]                    ext_rdata,
    output logic                          ext_refused,
    input  wire logic                     flash_done,
    output dnac_pkg::dnac_flash_req_t     flash_req,
    output logic                          done_flag
);
    import dnac_pkg::*;

    typedef enum logic [1:0] {
        DNAC_UNL_IDLE,
        DNAC_UNL_FIRST,
        DNAC_UNL_ARMED
    } dnac_unl_t;

    logic              space_r, config_space_select_r, erase_r, abort_r, permit_r;
    logic              write_r, read_r;
    logic [7:0]        index_r, value_r;
    logic              done_r, busy_r, tgt_flash_r, run_por_r;
    logic [DNAC_CNT_W-1:0] wcnt_r;
    logic [DNAC_CNT_W+4:0] pwrt_r;
    dnac_unl_t         unl_r;
    logic              pwr_block;
    logic              wr_acc, rd_acc;
    logic [7:0]        wbyte;
    logic              hit_ctrl, hit_unlock, hit_index, hit_value;
    logic              hit_flags, hit_status;
    logic              trig_write, trig_read, start_write, wr_finish;
    logic              ext_ok;
    dnac_target_t      target;
    dnac_mem_req_t     mem_req;
    logic [7:0]        mem_rdata;

    // ------------------------------------------------------------------
    // apb decode: zero-wait slave, unmapped reads zero with slverr
    // ------------------------------------------------------------------
    assign wbyte      = pwdata[7:0];
    assign wr_acc     = psel && penable && pwrite;
    assign rd_acc     = psel && penable && !pwrite;
    assign hit_ctrl   = (paddr == DNAC_OFS_CONTROL);
    assign hit_unlock = (paddr == DNAC_OFS_UNLOCK);
    assign hit_index  = (paddr == DNAC_OFS_INDEX);
    assign hit_value  = (paddr == DNAC_OFS_VALUE);
    assign hit_flags  = (paddr == DNAC_OFS_FLAGS);
    assign hit_status = (paddr == DNAC_OFS_STATUS);
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !(hit_ctrl || hit_unlock ||
                        hit_index || hit_value || hit_flags || hit_status);

    // ------------------------------------------------------------------
    // target selection
    // ------------------------------------------------------------------
    always_comb begin
        if (config_space_select_r) begin
            target = DNAC_TGT_CONFIG;
        end else if (space_r) begin
            target = DNAC_TGT_FLASH;
        end else begin
            target = DNAC_TGT_DATA;
        end
    end

    // ------------------------------------------------------------------
    // power-up timer: counts from power-on only, not other resets
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            pwrt_r <= '0;
        end else if (pwrt_r < (DNAC_CNT_W+5)'(PWRT_CYC)) begin
            pwrt_r <= pwrt_r + 1'b1;
        end
    end
    assign pwr_block = (pwrt_r < (DNAC_CNT_W+5)'(PWRT_CYC));

    // ------------------------------------------------------------------
    // trigger qualification
    // ------------------------------------------------------------------
    assign trig_write  = wr_acc && hit_ctrl && !busy_r && wbyte[DNAC_B_WRITE];
    // permit must already be set: the same write setting both fails
    assign start_write = trig_write && permit_r
                         && (unl_r == DNAC_UNL_ARMED)
                         && !pwr_block;
    assign trig_read   = wr_acc && hit_ctrl && !busy_r && wbyte[DNAC_B_READ]
                         && !wbyte[DNAC_B_SPACE] && !wbyte[DNAC_B_CONFIG_SPACE_SELECT];
    assign wr_finish   = busy_r && (tgt_flash_r ? flash_done
                         : (wcnt_r == (DNAC_CNT_W)'(WRITE_CYC - 1)));

    // ------------------------------------------------------------------
    // unlock sequence: any other register write disarms; reads leave it armed
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unl_r <= DNAC_UNL_IDLE;
        end else if (wr_acc && hit_unlock) begin
            unique case (unl_r)
                DNAC_UNL_IDLE:  unl_r <= (wbyte == DNAC_KEY_FIRST)
                                       ? DNAC_UNL_FIRST : DNAC_UNL_IDLE;
                DNAC_UNL_FIRST: unl_r <= (wbyte == DNAC_KEY_SECOND)
                                       ? DNAC_UNL_ARMED : DNAC_UNL_IDLE;
                DNAC_UNL_ARMED: unl_r <= (wbyte == DNAC_KEY_FIRST)
                                       ? DNAC_UNL_FIRST : DNAC_UNL_IDLE;
            endcase
        end else if (wr_acc) begin
            unl_r <= DNAC_UNL_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            permit_r <= 1'b0;
        end else if (wr_acc && hit_ctrl && !busy_r) begin
            permit_r <= wbyte[DNAC_B_PERMIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            space_r <= 1'b0;
            config_space_select_r  <= 1'b0;
            erase_r <= 1'b0;
        end else if (wr_finish) begin
            erase_r <= 1'b0;
        end else if (wr_acc && hit_ctrl && !busy_r) begin
            space_r <= wbyte[DNAC_B_SPACE];
            config_space_select_r  <= wbyte[DNAC_B_CONFIG_SPACE_SELECT];
            erase_r <= wbyte[DNAC_B_ERASE];
        end
    end

    // abort flag: set when a reset lands mid-write or trigger is refused
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            abort_r <= 1'b0;
        end else if (!presetn && run_por_r) begin
            abort_r <= 1'b1;
        end else if (trig_write && !start_write) begin
            abort_r <= 1'b1;
        end else if (wr_acc && hit_ctrl && !busy_r) begin
            abort_r <= wbyte[DNAC_B_ABORT];
        end
    end

    // write in flight, survives presetn so a cut write is seen
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            run_por_r <= 1'b0;
        end else if (!presetn || wr_finish) begin
            run_por_r <= 1'b0;
        end else if (start_write) begin
            run_por_r <= 1'b1;
        end
    end

    // write trigger and self-timed cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_r     <= 1'b0;
            busy_r      <= 1'b0;
            tgt_flash_r <= 1'b0;
            wcnt_r      <= '0;
        end else if (wr_finish) begin
            write_r <= 1'b0;
            busy_r  <= 1'b0;
            wcnt_r  <= '0;
        end else if (start_write) begin
            write_r     <= 1'b1;
            busy_r      <= 1'b1;
            tgt_flash_r <= (target != DNAC_TGT_DATA);
            wcnt_r      <= '0;
        end else if (busy_r) begin
            wcnt_r <= wcnt_r + 1'b1;
        end
    end

    // read trigger lasts one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_r <= 1'b0;
        end else begin
            read_r <= trig_read;
        end
    end

    // ------------------------------------------------------------------
    // index and value registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_r <= DNAC_RST_INDEX;
        end else if (wr_acc && hit_index && !busy_r) begin
            index_r <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_r <= DNAC_RST_VALUE;
        end else if (trig_read) begin
            value_r <= mem_rdata;
        end else if (wr_acc && hit_value && !busy_r) begin
            value_r <= wbyte;
        end
    end

    // ------------------------------------------------------------------
    // completion flag: set beats a same-cycle clear
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else if (wr_finish) begin
            done_r <= 1'b1;
        end else if (wr_acc && hit_flags && !wbyte[DNAC_B_DONE]) begin
            done_r <= 1'b0;
        end
    end
    assign done_flag = done_r;

    // ------------------------------------------------------------------
    // array port: processor while ext_prog_en is low, programmer only when unprotected
    // ------------------------------------------------------------------
    assign ext_ok      = !code_protect;
    assign ext_refused = ext_prog_en && (ext_rd || ext_wr) && !ext_ok;

    always_comb begin
        mem_req = '0;
        if (ext_prog_en) begin
            mem_req.index = ext_index;
            mem_req.wdata = ext_wdata;
            mem_req.en    = ext_ok && (ext_rd || ext_wr) && !busy_r;
            mem_req.wr    = ext_wr && !pwr_block;
        end else begin
            mem_req.index = trig_read ? index_r : index_r;
            mem_req.wdata = value_r;
            // processor access ignores protection
            mem_req.en    = wr_finish && !tgt_flash_r;
            mem_req.wr    = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_rdata <= 8'h00;
        end else if (ext_prog_en && ext_rd && ext_ok) begin
            ext_rdata <= mem_rdata;
        end
    end

    dnac_array u_array (
        .pclk    (pclk),
        .presetn (presetn),
        .req     (mem_req),
        .rdata   (mem_rdata)
    );

    // flash and config writes handed to the outside engine
    always_comb begin
        flash_req           = '0;
        flash_req.req       = start_write && (target != DNAC_TGT_DATA);
        flash_req.erase_row = erase_r;
        flash_req.is_config = (target == DNAC_TGT_CONFIG);
        flash_req.wdata     = value_r;
        flash_req.table_ptr = table_ptr;
    end

    // ------------------------------------------------------------------
    // read mux; unlock port has no storage and reads zero
    // ------------------------------------------------------------------
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_acc) begin
            if (hit_ctrl) begin
                prdata[DNAC_B_SPACE]  = space_r;
                prdata[DNAC_B_CONFIG_SPACE_SELECT]   = config_space_select_r;
                prdata[DNAC_B_ERASE]  = erase_r;
                prdata[DNAC_B_ABORT]  = abort_r;
                prdata[DNAC_B_PERMIT] = permit_r;
                prdata[DNAC_B_WRITE]  = write_r;
                prdata[DNAC_B_READ]   = read_r;
            end else if (hit_unlock) begin
                prdata = 32'h0000_0000;
            end else if (hit_index) begin
                prdata[7:0] = index_r;
            end else if (hit_value) begin
                prdata[7:0] = value_r;
            end else if (hit_flags) begin
                prdata[DNAC_B_DONE] = done_r;
            end else if (hit_status) begin
                prdata[DNAC_B_BUSY]   = busy_r;
                prdata[DNAC_B_ARMED]  = (unl_r == DNAC_UNL_ARMED);
                prdata[DNAC_B_PWRBLK] = pwr_block;
            end
        end
    end

endmodule : dnac_ctrl

/* File: dnac_pkg.sv */
// dnac_pkg: constants, register offsets and carrier types for the data
// nonvolatile access control block.
// assumes: 32-bit apb with word-aligned registers, 125 mhz pclk.
package dnac_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] DNAC_OFS_CONTROL = 8'h00;
    localparam logic [7:0] DNAC_OFS_UNLOCK  = 8'h04;
    localparam logic [7:0] DNAC_OFS_INDEX   = 8'h08;
    localparam logic [7:0] DNAC_OFS_VALUE   = 8'h0c;
    localparam logic [7:0] DNAC_OFS_FLAGS   = 8'h10;
    localparam logic [7:0] DNAC_OFS_STATUS  = 8'h14;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int DNAC_B_SPACE  = 7;
    localparam int DNAC_B_CONFIG_SPACE_SELECT   = 6;
    localparam int DNAC_B_ERASE  = 4;
    localparam int DNAC_B_ABORT  = 3;
    localparam int DNAC_B_PERMIT = 2;
    localparam int DNAC_B_WRITE  = 1;
    localparam int DNAC_B_READ   = 0;

    // flags register: completion flag bit
    localparam int DNAC_B_DONE   = 4;

    // status register fields
    localparam int DNAC_B_BUSY   = 0;
    localparam int DNAC_B_ARMED  = 1;
    localparam int DNAC_B_PWRBLK = 2;

    // ------------------------------------------------------------------
    // reset values and unlock keys
    // ------------------------------------------------------------------
    localparam logic [7:0] DNAC_RST_CONTROL = 8'h00;
    localparam logic [7:0] DNAC_RST_INDEX   = 8'h00;
    localparam logic [7:0] DNAC_RST_VALUE   = 8'h00;
    localparam logic [7:0] DNAC_KEY_FIRST   = 8'h55;
    localparam logic [7:0] DNAC_KEY_SECOND  = 8'haa;
    localparam logic [7:0] DNAC_ERASED      = 8'hff;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int DNAC_CLK_MHZ        = 125;
    localparam int DNAC_WRITE_US       = 4000;
    localparam int DNAC_WRITE_CYC      = DNAC_WRITE_US * DNAC_CLK_MHZ;
    localparam int DNAC_PWRT_US        = 65600;
    localparam int DNAC_PWRT_CYC       = DNAC_PWRT_US * DNAC_CLK_MHZ;
    localparam int DNAC_CNT_W          = 24;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DNAC_TGT_DATA,
        DNAC_TGT_FLASH,
        DNAC_TGT_CONFIG
    } dnac_target_t;

    typedef struct packed {
        logic       en;
        logic       wr;
        logic [7:0] index;
        logic [7:0] wdata;
    } dnac_mem_req_t;

    typedef struct packed {
        logic        req;
        logic        erase_row;
        logic        is_config;
        logic [7:0]  wdata;
        logic [20:0] table_ptr;
    } dnac_flash_req_t;

endpackage : dnac_pkg

/* File: dnac_array.sv */
// dnac_array: byte-wide data nonvolatile array with combinational read.
// assumes: one request at a time; write erases then programs the byte.
`timescale 1ns/10ps
module dnac_array (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire dnac_pkg::dnac_mem_req_t req,
    output logic [7:0]                  rdata
);
    import dnac_pkg::*;

    logic [7:0] mem_r [256];

    // ------------------------------------------------------------------
    // storage: erase-before-write folds into a single byte update
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 256; i++) begin
                mem_r[i] <= DNAC_ERASED;
            end
        end else if (req.en && req.wr) begin
            mem_r[req.index] <= req.wdata;
        end
    end

    assign rdata = mem_r[req.index];

endmodule : dnac_array

/* File: dnac_ctrl_sva.sv */
// dnac_ctrl_sva: port-level checks for the nvm access control block.
// assumes: bound to dnac_ctrl, one pclk domain, presetn async low.
`timescale 1ns/10ps
module dnac_ctrl_sva (
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [7:0]                paddr,
    input wire logic [31:0]               pwdata,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    input wire logic                      code_protect,
    input wire logic                      ext_prog_en,
    input wire logic                      ext_rd,
    input wire logic                      ext_wr,
    input wire logic                      ext_refused,
    input wire dnac_pkg::dnac_flash_req_t flash_req,
    input wire logic                      done_flag
);
    import dnac_pkg::*;
    logic acc;
    logic mapped;
    logic clr_done;
    assign acc = psel && penable;
    assign mapped = paddr inside {DNAC_OFS_CONTROL, DNAC_OFS_UNLOCK,
        DNAC_OFS_INDEX, DNAC_OFS_VALUE, DNAC_OFS_FLAGS, DNAC_OFS_STATUS};
    assign clr_done = acc && pwrite && paddr == DNAC_OFS_FLAGS
        && !pwdata[DNAC_B_DONE];
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // --------------------------------------------------------------
    // bus and register checks
    // --------------------------------------------------------------
    AST_IDLE_ZERO: assert property (!acc |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside access phase");
    AST_ZERO_WAIT: assert property (acc |-> pready)
        else $error("access phase without ready");
    AST_UNLOCK_ZERO: assert property (acc && !pwrite
        && paddr == DNAC_OFS_UNLOCK |-> prdata == 32'h0)
        else $error("unlock port read nonzero");
    AST_UPPER_ZERO: assert property (acc |-> prdata[31:8] == 24'h0)
        else $error("upper read bits nonzero");
    AST_UNMAPPED: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access without error");
    AST_MAPPED: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access flagged as error");
    AST_DONE_HOLD: assert property (done_flag && !clr_done
        |=> done_flag)
        else $error("done flag dropped without software clear");
    AST_REFUSE: assert property (ext_prog_en && (ext_rd || ext_wr)
        && code_protect |-> ext_refused)
        else $error("protected external access not refused");
    AST_ALLOW: assert property (!code_protect |-> !ext_refused)
        else $error("external access refused while unprotected");
    AST_FLASH_PULSE: assert property (flash_req.req |=> !flash_req.req)
        else $error("flash request longer than one cycle");
    CV_DONE: cover property ($rose(done_flag));
    CV_FLASH: cover property (flash_req.req && flash_req.erase_row);
    CV_UNMAPPED: cover property (acc && !mapped);
endmodule : dnac_ctrl_sva

bind dnac_ctrl dnac_ctrl_sva u_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .code_protect(code_protect), .ext_prog_en(ext_prog_en),
    .ext_rd(ext_rd), .ext_wr(ext_wr),
    .ext_refused(ext_refused), .flash_req(flash_req),
    .done_flag(done_flag));

/* File: dnac_flash_model.sv */
// dnac_flash_model: outside flash engine answering flash requests.
// assumes: request is a one-cycle pulse; done pulses some cycles later.
`timescale 1ns/10ps
module dnac_flash_model (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire dnac_pkg::dnac_flash_req_t flash_req,
    output logic                           flash_done,
    output logic                           erase_seen
);
    import dnac_pkg::*;
    logic [3:0] wait_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 4'h0;
            flash_done <= 1'b0;
            erase_seen <= 1'b0;
        end else begin
            flash_done <= (wait_r == 4'h1);
            if (flash_req.req) begin
                wait_r <= 4'h5;
                erase_seen <= flash_req.erase_row;
            end else if (wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
            end
        end
    end
endmodule : dnac_flash_model

/* File: test_data_nvm_access_control.sv */
// test_data_nvm_access_control: self-checking bench for dnac_ctrl.
// assumes: zero-wait apb slave, short write and power-up counts.
`timescale 1ns/10ps
module test_data_nvm_access_control;
    import dnac_pkg::*;
    typedef struct {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } dnac_row_t;
    logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0;
    logic pwrite = 0, pready, pslverr, code_protect = 0, ext_prog_en = 0;
    logic ext_rd = 0, ext_refused, flash_done, done_flag, erase_seen, err;
    logic [7:0] paddr = 8'h00, ext_index = 8'h00, ext_rdata;
    logic [31:0] pwdata = 32'h0, prdata, q;
    dnac_flash_req_t flash_req;
    int fails = 0, checked = 0;
    dnac_row_t rows [13] = '{'{0, 8'h14, 0, 32'h04},
        '{0, 8'h00, 0, 32'h00}, '{0, 8'h08, 0, 32'h00},
        '{0, 8'h0c, 0, 32'h00}, '{0, 8'h10, 0, 32'h00},
        '{1, 8'h04, 32'h55, 0}, '{0, 8'h04, 0, 32'h00},
        '{1, 8'h08, 32'h12, 0}, '{0, 8'h08, 0, 32'h12},
        '{1, 8'h00, 32'h01, 0}, '{0, 8'h0c, 0, 32'hff},
        '{0, 8'h00, 0, 32'h00}, '{0, 8'h04, 0, 32'h00}};
    dnac_ctrl #(.WRITE_CYC(20), .PWRT_CYC(4)) dut (.pclk(pclk),
        .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .table_ptr(21'h000040),
        .code_protect(code_protect), .ext_prog_en(ext_prog_en),
        .ext_rd(ext_rd), .ext_wr(1'b0), .ext_index(ext_index),
        .ext_wdata(8'h00), .ext_rdata(ext_rdata), .ext_refused(ext_refused),
        .flash_done(flash_done), .flash_req(flash_req),
        .done_flag(done_flag));
    dnac_flash_model u_flash (.pclk(pclk), .presetn(presetn),
        .flash_req(flash_req), .flash_done(flash_done),
        .erase_seen(erase_seen));
    initial begin
        forever #4 pclk = ~pclk;
    end
    // ------------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rchk
    task automatic unlock_go(input logic [31:0] ctl);
        apb(1'b1, DNAC_OFS_UNLOCK, {24'h0, DNAC_KEY_FIRST});
        apb(1'b1, DNAC_OFS_UNLOCK, {24'h0, DNAC_KEY_SECOND});
        apb(1'b1, DNAC_OFS_CONTROL, ctl);
    endtask : unlock_go
    task automatic wait_idle();
        for (int i = 0; i < 60; i++) begin
            apb(1'b0, DNAC_OFS_STATUS, 32'h0);
            if (q[DNAC_B_BUSY] === 1'b0) break;
        end
    endtask : wait_idle
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        tally_and_finish();
    end
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
            else rchk(rows[i].a, rows[i].e);
        end
        $display("test table done");
        apb(1'b1, DNAC_OFS_INDEX, 32'hcafe0105);
        apb(1'b1, DNAC_OFS_VALUE, 32'ha5);
        apb(1'b1, DNAC_OFS_CONTROL, 32'h04);
        unlock_go(32'h06);
        apb(1'b0, DNAC_OFS_STATUS, 32'h0);
        chk(q & 32'h1, 32'h1);
        apb(1'b1, DNAC_OFS_VALUE, 32'h77);
        wait_idle();
        rchk(DNAC_OFS_CONTROL, 32'h04);
        rchk(DNAC_OFS_FLAGS, 32'h10);
        chk(done_flag, 1'b1);
        rchk(DNAC_OFS_VALUE, 32'ha5);
        apb(1'b1, DNAC_OFS_VALUE, 32'h00);
        apb(1'b1, DNAC_OFS_CONTROL, 32'h05);
        rchk(DNAC_OFS_VALUE, 32'ha5);
        apb(1'b1, DNAC_OFS_FLAGS, 32'h0);
        rchk(DNAC_OFS_FLAGS, 32'h0);
        $display("test write done");
        apb(1'b1, DNAC_OFS_CONTROL, 32'h06);
        apb(1'b0, DNAC_OFS_STATUS, 32'h0);
        chk(q & 32'h1, 32'h0);
        rchk(DNAC_OFS_CONTROL, 32'h0c);
        apb(1'b1, DNAC_OFS_CONTROL, 32'h00);
        unlock_go(32'h06);
        apb(1'b0, DNAC_OFS_STATUS, 32'h0);
        chk(q & 32'h1, 32'h0);
        apb(1'b1, DNAC_OFS_CONTROL, 32'h00);
        $display("test refused write done");
        apb(1'b1, DNAC_OFS_VALUE, 32'h11);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, DNAC_OFS_CONTROL, k ? 32'h41 : 32'h81);
            rchk(DNAC_OFS_VALUE, 32'h11);
        end
        $display("test read block done");
        apb(1'b1, DNAC_OFS_CONTROL, 32'h94);
        unlock_go(32'h96);
        wait_idle();
        chk(erase_seen, 1'b1);
        rchk(DNAC_OFS_CONTROL, 32'h84);
        apb(1'b1, DNAC_OFS_CONTROL, 32'h00);
        $display("test flash erase done");
        apb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, err}, 32'h1);
        code_protect <= 1'b1;
        ext_prog_en <= 1'b1;
        ext_rd <= 1'b1;
        ext_index <= 8'h05;
        @(negedge pclk);
        chk(ext_refused, 1'b1);
        @(posedge pclk);
        code_protect <= 1'b0;
        @(negedge pclk);
        chk(ext_refused, 1'b0);
        @(negedge pclk);
        chk(ext_rdata, 8'ha5);
        $display("test unmapped and external done");
        tally_and_finish();
    end
endmodule : test_data_nvm_access_control
